/* File: rtl/timer_irq_level_regs.sv */
// Interrupt enable and priority level register bank for timer sources.
// Assumes an APB master on sys_clk_in and single-cycle event pulses.
`timescale 1ns/1ps
module timer_irq_level_regs #(
	parameter int ADDR_W = 12
)
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [timer_irq_pkg::NUM_SRC-1:0] timer_event_in,
	input wire logic [timer_irq_pkg::NUM_SRC-1:0] accept_in,
	output timer_irq_pkg::irq_req_t [timer_irq_pkg::NUM_SRC-1:0] irq_present_out,
	output logic irq_out
);

	localparam int NS = timer_irq_pkg::NUM_SRC;
	localparam int NR = timer_irq_pkg::NUM_LEVEL_REGS;
	localparam int PW = timer_irq_pkg::PRIO_W;
	localparam int NW = timer_irq_pkg::NIBBLE_W;

	// ==========================================================
	// Bus phases and decode
	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic [timer_irq_pkg::IDX_W-1:0] reg_idx;
	logic [NR-1:0] hit_level;
	logic hit_status;
	logic hit_mask;
	logic hit_any;
	logic [NS-1:0] byte_mask;

	assign setup_phase = psel_in && !penable_in;
	assign access_phase = psel_in && penable_in;
	assign wr_access = access_phase && pwrite_in && !pslverr_out;
	assign reg_idx = timer_irq_pkg::IDX_W'(paddr_in[ADDR_W-1:2]);
	assign byte_mask = {{(NS-8){pstrb_in[1]}}, {8{pstrb_in[0]}}};

	// Misaligned addresses are treated as their word
	always_comb
	begin
		hit_level = '0;
		hit_status = 1'b0;
		hit_mask = 1'b0;
		if (reg_idx == timer_irq_pkg::IDX_TIMER_B1_COMPARE_IRQ_LEVEL)
			hit_level[0] = 1'b1;
		else if (reg_idx == timer_irq_pkg::IDX_TIMER_B2_COMPARE_IRQ_LEVEL)
			hit_level[1] = 1'b1;
		else if (reg_idx == timer_irq_pkg::IDX_TIMER_B3_COMPARE_IRQ_LEVEL)
			hit_level[2] = 1'b1;
		else if (reg_idx == timer_irq_pkg::IDX_TIMER_B4_COMPARE_IRQ_LEVEL)
			hit_level[3] = 1'b1;
		else if (reg_idx == timer_irq_pkg::IDX_TIMER_B0_B1_OVERFLOW_IRQ_LEVEL)
			hit_level[4] = 1'b1;
		else if (reg_idx == timer_irq_pkg::IDX_EVENT_STATUS)
			hit_status = 1'b1;
		else if (reg_idx == timer_irq_pkg::IDX_EVENT_MASK)
			hit_mask = 1'b1;
	end

	assign hit_any = (|hit_level) || hit_status || hit_mask;

	// ==========================================================
	// Source slots
	logic [NS-1:0] flag;
	logic [PW-1:0] prio [NS];
	logic [7:0] level_byte [NR];

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++)
		begin : g_src
			logic prio_we;
			// Only byte lane 0 carries a level register
			assign prio_we = wr_access && hit_level[gi/2] && pstrb_in[0];
			irq_source_slot u_slot
			(
				.sys_clk_in(sys_clk_in),
				.resetn_in(resetn_in),
				.event_in(timer_event_in[gi]),
				.accept_in(accept_in[gi]),
				.prio_we_in(prio_we),
				.prio_wdata_in(pwdata_in[(gi%2)*NW +: PW]),
				.flag_out(flag[gi]),
				.prio_out(prio[gi]),
				.req_out(irq_present_out[gi])
			);
		end
		for (gi = 0; gi < NR; gi++)
		begin : g_byte
			assign level_byte[gi] = {flag[2*gi+1], prio[2*gi+1], flag[2*gi], prio[2*gi]};
		end
	endgenerate

	// ==========================================================
	// Event status and interrupt line
	logic [NS-1:0] status;
	logic [NS-1:0] mask;

	irq_event_status #(
		.N(NS)
	) u_status
	(
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.event_in(timer_event_in),
		.status_we_in(wr_access && hit_status),
		.mask_we_in(wr_access && hit_mask),
		.wdata_in(pwdata_in[NS-1:0]),
		.wmask_in(byte_mask),
		.status_out(status),
		.mask_out(mask),
		.irq_out(irq_out)
	);

	// ==========================================================
	// Read data and error, captured in the setup cycle
	// Capturing early keeps prdata registered with no wait state
	logic [31:0] rdata_next;
	logic [31:0] prdata_reg;
	logic slverr_reg;

	always_comb
	begin
		rdata_next = '0;
		for (int r = 0; r < NR; r++)
		begin
			if (hit_level[r])
				rdata_next = {24'h00_0000, level_byte[r]};
		end
		if (hit_status)
			rdata_next = 32'(status);
		else if (hit_mask)
			rdata_next = 32'(mask);
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			prdata_reg <= '0;
		else if (setup_phase && !pwrite_in)
			prdata_reg <= rdata_next;
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			slverr_reg <= 1'b0;
		else if (setup_phase)
			slverr_reg <= !hit_any;
	end

	assign prdata_out = prdata_reg;
	assign pready_out = access_phase;
	assign pslverr_out = access_phase && slverr_reg;

endmodule

/* File: common/timer_irq_pkg.sv */
// Package for the timer interrupt enable and level register bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package timer_irq_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_SRC = 10;
	localparam int NUM_LEVEL_REGS = 5;
	localparam int PRIO_W = 3;
	localparam int NIBBLE_W = 4;
	localparam int FLAG_BIT = 3;
	localparam int IDX_W = 10;

	// ==========================================================
	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TIMER_B1_COMPARE_IRQ_LEVEL = 10'h09a;
	localparam logic [IDX_W-1:0] IDX_TIMER_B2_COMPARE_IRQ_LEVEL = 10'h09b;
	localparam logic [IDX_W-1:0] IDX_TIMER_B3_COMPARE_IRQ_LEVEL = 10'h09c;
	localparam logic [IDX_W-1:0] IDX_TIMER_B4_COMPARE_IRQ_LEVEL = 10'h09d;
	localparam logic [IDX_W-1:0] IDX_TIMER_B0_B1_OVERFLOW_IRQ_LEVEL = 10'h09e;
	localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 10'h0c0;
	localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 10'h0c1;

	// ==========================================================
	// Reset values
	localparam logic [7:0] LEVEL_REG_RESET = 8'h00;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
	localparam logic [NUM_SRC-1:0] STATUS_RESET = 10'h000;
	localparam logic [NUM_SRC-1:0] MASK_RESET = 10'h000;

	// ==========================================================
	// Priority codes
	localparam logic [PRIO_W-1:0] PRIO_OFF_LOW = 3'h0;
	localparam logic [PRIO_W-1:0] PRIO_OFF_HIGH = 3'h7;

	// ==========================================================
	// Source numbering
	localparam int SRC_B1_CMP0 = 0;
	localparam int SRC_B1_CMP1 = 1;
	localparam int SRC_B2_CMP0 = 2;
	localparam int SRC_B2_CMP1 = 3;
	localparam int SRC_B3_CMP0 = 4;
	localparam int SRC_B3_CMP1 = 5;
	localparam int SRC_B4_CMP0 = 6;
	localparam int SRC_B4_CMP1 = 7;
	localparam int SRC_B0_OVF = 8;
	localparam int SRC_B1_OVF = 9;

	// ==========================================================
	// Request as presented to priority resolution
	typedef struct packed {
		logic pending;
		logic [PRIO_W-1:0] level;
	} irq_req_t;

endpackage

/* File: rtl/irq_source_slot.sv */
// One interrupt source: request flag and priority field.
// Assumes event and accept are one-cycle pulses on sys_clk_in.
`timescale 1ns/1ps
module irq_source_slot
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic event_in,
	input wire logic accept_in,
	input wire logic prio_we_in,
	input wire logic [timer_irq_pkg::PRIO_W-1:0] prio_wdata_in,
	output logic flag_out,
	output logic [timer_irq_pkg::PRIO_W-1:0] prio_out,
	output timer_irq_pkg::irq_req_t req_out
);

	logic flag_reg;
	logic [timer_irq_pkg::PRIO_W-1:0] prio_reg;
	logic enabled;

	// ==========================================================
	// Request flag
	// Set wins so an event in the accept cycle is not lost
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			flag_reg <= 1'b0;
		else if (event_in)
			flag_reg <= 1'b1;
		else if (accept_in)
			flag_reg <= 1'b0;
	end

	// ==========================================================
	// Priority field
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			prio_reg <= timer_irq_pkg::PRIO_RESET;
		else if (prio_we_in)
			prio_reg <= prio_wdata_in;
	end

	// ==========================================================
	// Presentation
	assign enabled = (prio_reg != timer_irq_pkg::PRIO_OFF_LOW)
		&& (prio_reg != timer_irq_pkg::PRIO_OFF_HIGH);
	assign req_out.pending = flag_reg && enabled;
	assign req_out.level = enabled ? prio_reg : timer_irq_pkg::PRIO_OFF_LOW;
	assign flag_out = flag_reg;
	assign prio_out = prio_reg;

endmodule

/* File: rtl/irq_event_status.sv */
// Sticky event status with write-one-to-clear, mask and one interrupt line.
// Assumes write strobes last one cycle.
`timescale 1ns/1ps
module irq_event_status #(
	parameter int N = 10
)
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [N-1:0] event_in,
	input wire logic status_we_in,
	input wire logic mask_we_in,
	input wire logic [N-1:0] wdata_in,
	input wire logic [N-1:0] wmask_in,
	output logic [N-1:0] status_out,
	output logic [N-1:0] mask_out,
	output logic irq_out
);

	logic [N-1:0] status_reg;
	logic [N-1:0] mask_reg;

	// ==========================================================
	// Status, set beats clear
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			status_reg <= N'(timer_irq_pkg::STATUS_RESET);
		else if (status_we_in)
			status_reg <= (status_reg & ~(wdata_in & wmask_in)) | event_in;
		else
			status_reg <= status_reg | event_in;
	end

	// ==========================================================
	// Mask
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			mask_reg <= N'(timer_irq_pkg::MASK_RESET);
		else if (mask_we_in)
			mask_reg <= (mask_reg & ~wmask_in) | (wdata_in & wmask_in);
	end

	assign status_out = status_reg;
	assign mask_out = mask_reg;
	assign irq_out = |(status_reg & mask_reg);

endmodule

/* File: tb/timer_irq_level_regs_asserts.sv */
// Port-level checks for the timer interrupt level bank.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module timer_irq_level_regs_asserts #(
	parameter int ADDR_W = 12
)
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [timer_irq_pkg::NUM_SRC-1:0] timer_event_in,
	input wire logic [timer_irq_pkg::NUM_SRC-1:0] accept_in,
	input wire timer_irq_pkg::irq_req_t [timer_irq_pkg::NUM_SRC-1:0] irq_present_out,
	input wire logic irq_out
);
	// ==========================================================
	// Helper logic
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	wire acc = psel_in && penable_in;
	wire wr = acc && pwrite_in;
	wire [ADDR_W-3:0] idx = paddr_in[ADDR_W-1:2];
	wire timer_irq_pkg::irq_req_t s0 = irq_present_out[0];
	logic [2:0] prio0_reg;
	// Shadow of source 0 priority, so checks need no read-back
	always_ff @(posedge sys_clk_in or negedge resetn_in)
		if (!resetn_in)
			prio0_reg <= 3'h0;
		else if (wr && idx == timer_irq_pkg::IDX_TIMER_B1_COMPARE_IRQ_LEVEL && pstrb_in[0])
			prio0_reg <= pwdata_in[2:0];
	// ==========================================================
	// Assertions
	map_ok_a: assert property (acc && idx inside {[10'h09a:10'h09e]} |-> !pslverr_out)
		else $error("mapped level register refused");
	rd_err_a: assert property (acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0)
		else $error("unmapped read returned data");
	pend_lvl_a: assert property (s0.pending |-> s0.level inside {[3'h1:3'h6]})
		else $error("pending source without a valid level");
	lvl_match_a: assert property (s0.pending |-> s0.level == prio0_reg)
		else $error("presented level differs from written code");
	no_seven_a: assert property (s0.level != 3'h7)
		else $error("code seven presented as a level");
	evt_set_a: assert property (timer_event_in[0] |=> s0.pending == (prio0_reg inside {[1:6]}))
		else $error("event did not give the expected request");
	acc_clr_a: assert property (accept_in[0] && !timer_event_in[0] |=> !s0.pending)
		else $error("accepted request still pending");
	flag_hold_a: assert property (s0.pending && !accept_in[0] && !wr |=> s0.pending)
		else $error("request dropped without acceptance");
	no_spont_a: assert property (!s0.pending && !timer_event_in[0] && !wr |=> !s0.pending)
		else $error("request appeared without an event");
	cover property (timer_event_in[0] ##1 s0.pending);
	cover property (accept_in[0] ##1 !s0.pending);
	cover property (acc && pslverr_out);
endmodule
bind timer_irq_level_regs timer_irq_level_regs_asserts #(.ADDR_W(ADDR_W)) chk (.*);

/* File: tb/irq_resolver_model.sv */
// Processor side model: accepts the highest presented request.
// Assumes stall_in from the bench to answer slowly.
`timescale 1ns/1ps
module irq_resolver_model
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic stall_in,
	input wire timer_irq_pkg::irq_req_t [timer_irq_pkg::NUM_SRC-1:0] req_in,
	output logic [timer_irq_pkg::NUM_SRC-1:0] accept_out
);
	// ==========================================================
	// Selection and acceptance
	int win;
	always_comb
	begin
		win = -1;
		for (int i = 0; i < timer_irq_pkg::NUM_SRC; i++)
			if (req_in[i].pending && (win < 0 || req_in[i].level > req_in[win].level))
				win = i;
	end
	// Gap after each pulse, since the flag clears one edge later
	always_ff @(posedge sys_clk_in or negedge resetn_in)
		if (!resetn_in)
			accept_out <= '0;
		else if (!stall_in && accept_out == '0 && win >= 0)
			accept_out <= 10'h001 << win;
		else
			accept_out <= '0;
endmodule

/* File: tb/tb_timer_irq_level_regs.sv */
// Self-checking bench for the timer interrupt level bank.
// Assumes zero-wait APB answers are still awaited on pready.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_timer_irq_level_regs;
	// ==========================================================
	// Signals and instances
	logic sys_clk_in = 0;
	logic resetn_in = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic stall = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [9:0] event_vec = 10'h000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq, err, p;
	logic [9:0] accept;
	timer_irq_pkg::irq_req_t [9:0] present;
	int num_errors = 0;
	int tests_run = 0;
	always #20 sys_clk_in = ~sys_clk_in;
	timer_irq_level_regs dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.timer_event_in(event_vec), .accept_in(accept), .irq_present_out(present), .irq_out(irq));
	irq_resolver_model cpu (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .stall_in(stall),
		.req_in(present), .accept_out(accept));
	// ==========================================================
	// Tasks
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		@(posedge sys_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		do
			@(posedge sys_clk_in);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge sys_clk_in);
	endtask
	task automatic pulse(input logic [9:0] m);
		@(posedge sys_clk_in);
		event_vec <= m;
		@(posedge sys_clk_in);
		event_vec <= 10'h000;
		@(negedge sys_clk_in);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, timer_irq_pkg::IDX_TIMER_B1_COMPARE_IRQ_LEVEL + 10'(i), '0);
			`CHK("level reset", 32'h0000_0000, q)
		end
		apb(1'b0, timer_irq_pkg::IDX_EVENT_STATUS, '0);
		`CHK("status reset", 32'h0000_0000, q)
		`CHK("present reset", 40'h00_0000_0000, present)
		`CHK("irq reset", 1'b0, irq)
		$display("test reset done");
	endtask
	task automatic t_codes;
		logic [9:0] a;
		for (int c = 0; c < 8; c++)
		begin
			a = timer_irq_pkg::IDX_TIMER_B1_COMPARE_IRQ_LEVEL + 10'(c % 5);
			apb(1'b1, a, {24'h0, 1'b1, 3'(c), 1'b1, 3'(7 - c)});
			apb(1'b0, a, '0);
			`CHK("level rw", {25'h0, 3'(c), 1'b0, 3'(7 - c)}, q)
		end
		// Level write with byte lane 0 off must leave the register alone
		@(posedge sys_clk_in);
		pstrb <= 4'he;
		apb(1'b1, a, 32'h0000_0011);
		@(posedge sys_clk_in);
		pstrb <= 4'hf;
		apb(1'b0, a, '0);
		`CHK("lane0 off", 32'h0000_0070, q)
		apb(1'b1, 10'h09f, 32'hffff_ffff);
		`CHK("unmapped err", 1'b1, err)
		apb(1'b0, 10'h09f, '0);
		`CHK("unmapped data", 32'h0000_0000, q)
		`CHK("unmapped rd err", 1'b1, err)
		$display("test codes done");
	endtask
	task automatic t_events;
		for (int c = 0; c < 8; c++)
		begin
			@(posedge sys_clk_in);
			stall <= 1'b1;
			apb(1'b1, timer_irq_pkg::IDX_TIMER_B1_COMPARE_IRQ_LEVEL, {29'h0, 3'(c)});
			pulse(10'h001);
			p = (c >= 1 && c <= 6);
			`CHK("present0", {p, p ? 3'(c) : 3'h0}, present[0])
			apb(1'b0, timer_irq_pkg::IDX_TIMER_B1_COMPARE_IRQ_LEVEL, '0);
			`CHK("flag0", 32'(8 + c), q)
			@(posedge sys_clk_in);
			stall <= 1'b0;
			repeat (4) @(negedge sys_clk_in);
			`CHK("accepted0", 1'b0, present[0].pending)
		end
		@(posedge sys_clk_in);
		stall <= 1'b1;
		apb(1'b1, timer_irq_pkg::IDX_TIMER_B0_B1_OVERFLOW_IRQ_LEVEL, 32'h0000_0050);
		pulse(10'h200);
		`CHK("present9", 4'hd, present[9])
		apb(1'b0, timer_irq_pkg::IDX_TIMER_B0_B1_OVERFLOW_IRQ_LEVEL, '0);
		`CHK("flag9", 32'h0000_00d0, q)
		@(posedge sys_clk_in);
		stall <= 1'b0;
		repeat (4) @(negedge sys_clk_in);
		`CHK("accepted9", 1'b0, present[9].pending)
		$display("test events done");
	endtask
	task automatic t_irq;
		apb(1'b1, timer_irq_pkg::IDX_EVENT_MASK, 32'h0000_0004);
		pulse(10'h006);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b1, timer_irq_pkg::IDX_EVENT_STATUS, 32'h0000_0004);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b0, timer_irq_pkg::IDX_EVENT_STATUS, '0);
		`CHK("status", 32'h0000_0203, q)
		apb(1'b1, timer_irq_pkg::IDX_EVENT_MASK, 32'h0000_0001);
		`CHK("irq unmasked", 1'b1, irq)
		apb(1'b1, timer_irq_pkg::IDX_EVENT_MASK, 32'h0000_0000);
		`CHK("irq masked", 1'b0, irq)
		$display("test irq done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// Sequence and watchdog
	initial
	begin
		repeat (8) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		t_reset();
		t_codes();
		t_events();
		t_irq();
		// Reset in mid-run, with flags and codes set, must clear the bank again
		@(posedge sys_clk_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		t_reset();
		end_of_test();
	end
	initial
	begin
		#400000;
		num_errors++;
		end_of_test();
	end
endmodule
